// ### hw/csr_pkg.sv
`default_nettype none
package csr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Special register addresses (direct addressing, upper 128 locations)
   localparam logic [7:0] ADDR_STACK_PTR = 8'h81;
   localparam logic [7:0] ADDR_MEM_PTR_LO = 8'h82;
   localparam logic [7:0] ADDR_MEM_PTR_HI = 8'h83;
   localparam logic [7:0] ADDR_POWER_CTL = 8'h87;
   localparam logic [7:0] ADDR_REV_ID    = 8'hC2;
   localparam logic [7:0] ADDR_STATUS    = 8'hD0;
   localparam logic [7:0] ADDR_ARITH     = 8'hE0;
   localparam logic [7:0] ADDR_AUX       = 8'hF0;

   ////////////////////////////////////////////////////////////////////////////
   // Values after reset, and the value read at unmapped addresses
   localparam logic [7:0] RST_STACK_PTR = 8'h07;
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam logic [7:0] RST_POWER_CTL = 8'h00;
   localparam logic [7:0] RST_STATUS    = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Status word field positions
   localparam int unsigned ST_CARRY  = 7;
   localparam int unsigned ST_HALF   = 6;
   localparam int unsigned ST_USER0  = 5;
   localparam int unsigned ST_BANK_H = 4;
   localparam int unsigned ST_BANK_L = 3;
   localparam int unsigned ST_RANGE  = 2;
   localparam int unsigned ST_USER1  = 1;
   localparam int unsigned ST_PARITY = 0;

   // Power control field positions
   localparam int unsigned PC_BAUD_DOUBLE = 7;
   localparam int unsigned PC_SERIAL_WAKE = 6;
   localparam int unsigned PC_EXT0_WAKE   = 5;
   localparam int unsigned PC_RESERVED    = 4;
   localparam int unsigned PC_POWER_DOWN  = 1;
   localparam int unsigned PC_CORE_HALT   = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Result of an executed instruction, loaded by hardware
   typedef struct packed {
      logic       acc_we;
      logic [7:0] acc;
      logic       aux_we;
      logic [7:0] aux;
      logic       carry_we;
      logic       carry;
      logic       half_we;
      logic       half;
      logic       range_we;
      logic       range;
   } csr_alu_upd_t;

   // Byte that holds a given bit address (bit-addressable bytes end in 0H or 8H)
   function automatic logic [7:0] csr_bit_byte(input logic [7:0] bit_addr);
      return {bit_addr[7:3], 3'h0};
   endfunction : csr_bit_byte

   function automatic logic csr_bit_capable(input logic [7:0] byte_addr);
      return byte_addr[2:0] == 3'h0;
   endfunction : csr_bit_capable

endpackage : csr_pkg
`default_nettype wire

// ### hw/csr_sfr_byte.sv
`default_nettype none
module csr_sfr_byte
   import csr_pkg::*;
#(
   parameter logic [7:0] ADDR   = 8'h00,
   parameter logic [7:0] RST    = 8'h00,
   parameter bit         BIT_OK = 1'b0
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Direct byte write
   input  wire logic [7:0] wr_addr,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   // Single-bit write
   input  wire logic [7:0] bit_addr,
   input  wire logic       bit_en,
   input  wire logic       bit_val,
   // Hardware load, wins over software
   input  wire logic       hw_en,
   input  wire logic [7:0] hw_data,
   // Contents
   output logic [7:0]      q
);

   logic [7:0] next_q;

   always_comb begin
      next_q = q;
      if (hw_en)
         next_q = hw_data;
      else if (wr_en && wr_addr == ADDR)
         next_q = wr_data;
      else if (BIT_OK && bit_en && csr_bit_byte(bit_addr) == ADDR) // R13
         next_q[bit_addr[2:0]] = bit_val;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         q <= RST;
      else
         q <= next_q;
   end

endmodule : csr_sfr_byte
`default_nettype wire

// ### hw/csr_core_regs.sv
// What this block does
// R1: Push increments pointer, then writes stack RAM
// R2: Stack pointer resets to 07H; first push 08H
// R3: Memory pointer usable as 16-bit or two bytes
// R4: Status word at D0H, reset 00H, bit-addressable
// R5: Status word flag layout carry..parity
// R6: Bank bits select bank 0 to 3 binary
// R7: Power control at 87H, reset 00H, byte only
// R8: Power control bit layout baud..idle
// R9: Main arithmetic register holds operands and results
// R10: Auxiliary register pairs for multiply/divide, else scratch
// R11: Unoccupied addresses hold no register
// R12: Software avoids reserved locations
// R13: Addresses ending 0H or 8H are bit-addressable
// R14: Readable silicon revision byte
// R15: All CPU registers except PC/banks here
// R16: Only direct access reaches this space
// R17: Lowest 32 bytes form four register banks
// R18: Parity flag tracks main register, ignores writes
`default_nettype none
module csr_core_regs
   import csr_pkg::*;
#(
   // Arbitrary value; changes with silicon revision
   parameter logic [7:0] REVISION_ID = 8'h5A
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst_n,
   // Direct byte access (upper 128 addresses)
   input  wire logic [7:0]   dir_addr,
   input  wire logic         dir_wr,
   input  wire logic [7:0]   dir_wdata,
   input  wire logic         dir_rd,
   output logic [7:0]        dir_rdata,
   output logic              sfr_hit,
   // Single-bit access
   input  wire logic [7:0]   bit_addr,
   input  wire logic         bit_wr,
   input  wire logic         bit_wval,
   input  wire logic         bit_rd,
   output logic              bit_rdata,
   // Instruction results
   input  wire csr_alu_upd_t alu_upd,
   input  wire logic         mem_pointer_word_we,
   input  wire logic [15:0]  mem_pointer_word_data,
   // Stack operations
   input  wire logic         push_req,
   input  wire logic [7:0]   push_data,
   input  wire logic         pop_req,
   output logic              stack_we,
   output logic [7:0]        stack_addr,
   output logic [7:0]        stack_wdata,
   // Working register addressing
   input  wire logic [2:0]   wreg_idx,
   output logic [7:0]        wreg_addr,
   // Register contents
   output logic [7:0]        arith_main_reg,
   output logic [7:0]        mul_aux_reg,
   output logic [7:0]        stack_top_pointer,
   output logic [15:0]       mem_pointer_word,
   output logic [7:0]        cpu_status_word,
   output logic [7:0]        power_control_reg,
   output logic              power_down_enable,
   output logic              core_halt_enable
);

   ////////////////////////////////////////////////////////////////////////////
   // Hardware loads

   logic [7:0] mem_pointer_high;
   logic [7:0] mem_pointer_low;
   logic [7:0] status_q;
   logic       sp_hw_en;
   logic [7:0] sp_hw_data;
   logic       st_hw_en;
   logic [7:0] st_hw_data;

   always_comb begin
      // Push wins over a simultaneous pop
      sp_hw_en   = push_req || pop_req;
      sp_hw_data = push_req ? stack_top_pointer + 8'h01 : stack_top_pointer - 8'h01; // R1
      st_hw_en   = alu_upd.carry_we || alu_upd.half_we || alu_upd.range_we;
      st_hw_data = status_q;
      if (alu_upd.carry_we)
         st_hw_data[ST_CARRY] = alu_upd.carry; // R5
      if (alu_upd.half_we)
         st_hw_data[ST_HALF] = alu_upd.half;
      if (alu_upd.range_we)
         st_hw_data[ST_RANGE] = alu_upd.range;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register instances

   csr_sfr_byte #(.ADDR(ADDR_ARITH), .RST(RST_ZERO), .BIT_OK(1'b1)) u_arith ( // R9
      .clock(clock), .rst_n(rst_n),
      .wr_addr(dir_addr), .wr_en(dir_wr), .wr_data(dir_wdata),
      .bit_addr(bit_addr), .bit_en(bit_wr), .bit_val(bit_wval),
      .hw_en(alu_upd.acc_we), .hw_data(alu_upd.acc), .q(arith_main_reg));

   csr_sfr_byte #(.ADDR(ADDR_AUX), .RST(RST_ZERO), .BIT_OK(1'b1)) u_aux ( // R10
      .clock(clock), .rst_n(rst_n),
      .wr_addr(dir_addr), .wr_en(dir_wr), .wr_data(dir_wdata),
      .bit_addr(bit_addr), .bit_en(bit_wr), .bit_val(bit_wval),
      .hw_en(alu_upd.aux_we), .hw_data(alu_upd.aux), .q(mul_aux_reg));

   csr_sfr_byte #(.ADDR(ADDR_STACK_PTR), .RST(RST_STACK_PTR), .BIT_OK(1'b0)) u_sp ( // R2
      .clock(clock), .rst_n(rst_n),
      .wr_addr(dir_addr), .wr_en(dir_wr), .wr_data(dir_wdata),
      .bit_addr(bit_addr), .bit_en(bit_wr), .bit_val(bit_wval),
      .hw_en(sp_hw_en), .hw_data(sp_hw_data), .q(stack_top_pointer));

   csr_sfr_byte #(.ADDR(ADDR_MEM_PTR_LO), .RST(RST_ZERO), .BIT_OK(1'b0)) u_dpl ( // R3
      .clock(clock), .rst_n(rst_n),
      .wr_addr(dir_addr), .wr_en(dir_wr), .wr_data(dir_wdata),
      .bit_addr(bit_addr), .bit_en(bit_wr), .bit_val(bit_wval),
      .hw_en(mem_pointer_word_we), .hw_data(mem_pointer_word_data[7:0]), .q(mem_pointer_low));

   csr_sfr_byte #(.ADDR(ADDR_MEM_PTR_HI), .RST(RST_ZERO), .BIT_OK(1'b0)) u_dph ( // R3
      .clock(clock), .rst_n(rst_n),
      .wr_addr(dir_addr), .wr_en(dir_wr), .wr_data(dir_wdata),
      .bit_addr(bit_addr), .bit_en(bit_wr), .bit_val(bit_wval),
      .hw_en(mem_pointer_word_we), .hw_data(mem_pointer_word_data[15:8]), .q(mem_pointer_high));

   csr_sfr_byte #(.ADDR(ADDR_STATUS), .RST(RST_STATUS), .BIT_OK(1'b1)) u_status ( // R4
      .clock(clock), .rst_n(rst_n),
      .wr_addr(dir_addr), .wr_en(dir_wr), .wr_data(dir_wdata),
      .bit_addr(bit_addr), .bit_en(bit_wr), .bit_val(bit_wval),
      .hw_en(st_hw_en), .hw_data(st_hw_data), .q(status_q));

   // Bit-addressable flag off: bit writes can never reach this byte
   csr_sfr_byte #(.ADDR(ADDR_POWER_CTL), .RST(RST_POWER_CTL), .BIT_OK(1'b0)) u_power_control_reg ( // R7
      .clock(clock), .rst_n(rst_n),
      .wr_addr(dir_addr), .wr_en(dir_wr), .wr_data(dir_wdata),
      .bit_addr(bit_addr), .bit_en(bit_wr), .bit_val(bit_wval),
      .hw_en(1'b0), .hw_data(RST_POWER_CTL), .q(power_control_reg));

   ////////////////////////////////////////////////////////////////////////////
   // Derived outputs

   always_comb begin
      mem_pointer_word = {mem_pointer_high, mem_pointer_low}; // R3
      // Stored parity bit is dead; the live value always comes from the accumulator
      cpu_status_word = {status_q[7:1], ^arith_main_reg}; // R18
      // Bank base is bank*8 within the lowest 32 bytes
      wreg_addr = {3'h0, status_q[ST_BANK_H], status_q[ST_BANK_L], wreg_idx}; // R6 R17
      power_down_enable = power_control_reg[PC_POWER_DOWN]; // R8
      core_halt_enable  = power_control_reg[PC_CORE_HALT];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read decode

   function automatic logic [8:0] read_byte(input logic [7:0] a);
      // Bit 8 flags a mapped location
      logic [8:0] r;
      r = {1'b0, UNMAPPED_READ};
      // Only the upper half is decoded: low addresses are RAM, never this space
      if (a[7]) begin // R16
         unique case (a) // R15
            ADDR_ARITH:     r = {1'b1, arith_main_reg};
            ADDR_AUX:       r = {1'b1, mul_aux_reg};
            ADDR_STACK_PTR: r = {1'b1, stack_top_pointer};
            ADDR_MEM_PTR_LO: r = {1'b1, mem_pointer_low};
            ADDR_MEM_PTR_HI: r = {1'b1, mem_pointer_high};
            ADDR_STATUS:    r = {1'b1, cpu_status_word};
            ADDR_POWER_CTL: r = {1'b1, power_control_reg};
            ADDR_REV_ID:    r = {1'b1, REVISION_ID}; // R14
            default:        r = {1'b0, UNMAPPED_READ}; // R11
         endcase
      end
      return r;
   endfunction : read_byte

   logic [8:0] dir_look;
   logic [8:0] bit_look;
   logic [7:0] next_dir_rdata;
   logic       next_bit_rdata;
   logic       next_stack_we;
   logic [7:0] next_stack_addr;
   logic [7:0] next_stack_wdata;

   always_comb begin
      dir_look  = read_byte(dir_addr);
      bit_look  = read_byte(csr_bit_byte(bit_addr));
      sfr_hit   = dir_look[8];
      next_dir_rdata = dir_rd ? dir_look[7:0] : dir_rdata;
      next_bit_rdata = bit_rdata;
      if (bit_rd)
         next_bit_rdata = bit_look[bit_addr[2:0]] && csr_bit_capable(csr_bit_byte(bit_addr)); // R13
      // Stack write uses the pointer value after the increment
      next_stack_we    = push_req; // R1
      next_stack_addr  = push_req ? sp_hw_data : stack_addr;
      next_stack_wdata = push_req ? push_data : stack_wdata;
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dir_rdata   <= RST_ZERO;
         bit_rdata   <= 1'b0;
         stack_we    <= 1'b0;
         stack_addr  <= RST_ZERO;
         stack_wdata <= RST_ZERO;
      end else begin
         dir_rdata   <= next_dir_rdata;
         bit_rdata   <= next_bit_rdata;
         stack_we    <= next_stack_we;
         stack_addr  <= next_stack_addr;
         stack_wdata <= next_stack_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   logic seen_edge;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         seen_edge <= 1'b0;
      else
         seen_edge <= 1'b1;
   end

   AST_PUSH_ORDER: assert property (push_req |=> stack_we && // R1
      stack_addr == $past(stack_top_pointer) + 8'h01 && stack_top_pointer == stack_addr)
      else $error("push did not increment before writing");
   AST_SP_RESET: assert property (!seen_edge |-> stack_top_pointer == RST_STACK_PTR) // R2
      else $error("stack pointer not 07H after reset");
   AST_MEM_POINTER_WORD_WORD: assert property (mem_pointer_word_we |=> mem_pointer_word == $past(mem_pointer_word_data)) // R3
      else $error("memory pointer word load lost");
   AST_STATUS_BIT: assert property (bit_wr && !dir_wr && !st_hw_en && // R4
      bit_addr == (ADDR_STATUS | 8'h05) |=> cpu_status_word[ST_USER0] == $past(bit_wval))
      else $error("status bit write failed");
   AST_BANK_ADDR: assert property (wreg_addr == {3'h0, cpu_status_word[4:3], wreg_idx}) // R6
      else $error("working register address wrong");
   AST_POWER_CONTROL_REG_BYTE: assert property (bit_wr && !dir_wr |=> $stable(power_control_reg)) // R7
      else $error("power control changed by bit write");
   AST_AUX_LOAD: assert property (alu_upd.aux_we |=> mul_aux_reg == $past(alu_upd.aux)) // R10
      else $error("auxiliary register load lost");
   AST_UNMAPPED: assert property (dir_rd && !sfr_hit |=> dir_rdata == UNMAPPED_READ) // R11
      else $error("unmapped read returned data");
   AST_REV_ID: assert property (dir_rd && dir_addr == ADDR_REV_ID |=> dir_rdata == REVISION_ID) // R14
      else $error("revision byte wrong");
   AST_PARITY: assert property (alu_upd.acc_we |=> cpu_status_word[0] == ^$past(alu_upd.acc)) // R18
      else $error("parity does not track accumulator");

   COV_PUSH: cover property (push_req ##1 push_req);
   COV_POP: cover property (push_req ##1 pop_req);
   COV_BANK3: cover property (cpu_status_word[4:3] == 2'h3);
   COV_BIT_READ: cover property (bit_rd ##1 bit_rdata);

endmodule : csr_core_regs
`default_nettype wire

// ### testbench/tb_csr_core_regs.sv
`default_nettype none
module tb_csr_core_regs
   import csr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // Arbitrary revision value, distinct from the design default
   localparam logic [7:0] REV = 8'h3C;

   logic         clock             = 1'b0;
   logic         rst_n             = 1'b0;
   logic [7:0]   dir_addr          = 8'h00;
   logic         dir_wr            = 1'b0;
   logic [7:0]   dir_wdata         = 8'h00;
   logic         dir_rd            = 1'b0;
   logic [7:0]   bit_addr          = 8'h00;
   logic         bit_wr            = 1'b0;
   logic         bit_wval          = 1'b0;
   logic         bit_rd            = 1'b0;
   csr_alu_upd_t alu_upd           = '0;
   logic         mem_pointer_word_we           = 1'b0;
   logic [15:0]  mem_pointer_word_data         = 16'h0000;
   logic         push_req          = 1'b0;
   logic [7:0]   push_data         = 8'h00;
   logic         pop_req           = 1'b0;
   logic [2:0]   wreg_idx          = 3'h0;
   logic [7:0]   dir_rdata, stack_addr, stack_wdata, wreg_addr, arith_main_reg, mul_aux_reg;
   logic [7:0]   stack_top_pointer, cpu_status_word, power_control_reg;
   logic [15:0]  mem_pointer_word;
   logic         sfr_hit, bit_rdata, stack_we, power_down_enable, core_halt_enable;
   logic [7:0]   mdl [128:255];
   logic [31:0]  rnd               = 32'h00017E09;
   int           n_fail            = 0;
   int           checks            = 0;
   // Mapped, read-only and unoccupied addresses mixed; reserved ones are never touched
   logic [7:0]   tbl [11] = '{8'h81, 8'h82, 8'h83, 8'h87, 8'hC2, 8'hD0, 8'hE0, 8'hF0,
                              8'h80, 8'h85, 8'hFF};

   always #20 clock = ~clock;

   csr_core_regs #(.REVISION_ID(REV)) dut (
      .clock(clock), .rst_n(rst_n), .dir_addr(dir_addr), .dir_wr(dir_wr),
      .dir_wdata(dir_wdata), .dir_rd(dir_rd), .dir_rdata(dir_rdata), .sfr_hit(sfr_hit),
      .bit_addr(bit_addr), .bit_wr(bit_wr), .bit_wval(bit_wval), .bit_rd(bit_rd),
      .bit_rdata(bit_rdata), .alu_upd(alu_upd), .mem_pointer_word_we(mem_pointer_word_we), .mem_pointer_word_data(mem_pointer_word_data),
      .push_req(push_req), .push_data(push_data), .pop_req(pop_req), .stack_we(stack_we),
      .stack_addr(stack_addr), .stack_wdata(stack_wdata), .wreg_idx(wreg_idx),
      .wreg_addr(wreg_addr), .arith_main_reg(arith_main_reg), .mul_aux_reg(mul_aux_reg),
      .stack_top_pointer(stack_top_pointer), .mem_pointer_word(mem_pointer_word),
      .cpu_status_word(cpu_status_word), .power_control_reg(power_control_reg),
      .power_down_enable(power_down_enable), .core_halt_enable(core_halt_enable));

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic mapped(input logic [7:0] a);
      return a inside {8'h81, 8'h82, 8'h83, 8'h87, 8'hC2, 8'hD0, 8'hE0, 8'hF0};
   endfunction : mapped

   // Parity is always live from the main register, never the stored bit
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      if (a == 8'hD0) return {mdl[8'hD0][7:1], ^mdl[8'hE0]};
      if (a == 8'hC2) return REV;
      return mapped(a) ? mdl[a] : UNMAPPED_READ;
   endfunction : exp_rd

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic end_sim();
      if (n_fail == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic reset_model();
      for (int i = 128; i < 256; i++) mdl[i] = 8'h00;
      mdl[8'h81] = RST_STACK_PTR;
   endtask : reset_model

   task automatic chk_outs();
      check("sp", stack_top_pointer, mdl[8'h81]);
      check("mem_pointer_word", mem_pointer_word, {mdl[8'h83], mdl[8'h82]});
      check("acc", arith_main_reg, mdl[8'hE0]);
      check("aux", mul_aux_reg, mdl[8'hF0]);
      check("psw", cpu_status_word, exp_rd(8'hD0));
      check("power_control_reg", power_control_reg, mdl[8'h87]);
      check("pd_idl", {power_down_enable, core_halt_enable}, mdl[8'h87][1:0]);
      check("wreg", wreg_addr, {3'h0, mdl[8'hD0][4:3], wreg_idx});
   endtask : chk_outs

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      dir_wr <= 1'b1;
      dir_addr <= a;
      dir_wdata <= d;
      wreg_idx <= d[5:3];
      @(posedge clock);
      dir_wr <= 1'b0;
      if (mapped(a) && a != 8'hC2) mdl[a] = d;
      #1 chk_outs();
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      dir_rd <= 1'b1;
      dir_addr <= a;
      #1 check("hit", sfr_hit, mapped(a));
      @(posedge clock);
      dir_rd <= 1'b0;
      #1 check("rdata", dir_rdata, exp_rd(a));
   endtask : rd

   task automatic bw(input logic [7:0] ba, input logic v);
      @(posedge clock);
      bit_wr <= 1'b1;
      bit_addr <= ba;
      bit_wval <= v;
      @(posedge clock);
      bit_wr <= 1'b0;
      mdl[{ba[7:3], 3'h0}][ba[2:0]] = v;
      #1 chk_outs();
   endtask : bw

   task automatic br(input logic [7:0] ba);
      logic [7:0] e;
      e = exp_rd({ba[7:3], 3'h0});
      @(posedge clock);
      bit_rd <= 1'b1;
      bit_addr <= ba;
      @(posedge clock);
      bit_rd <= 1'b0;
      #1 check("bit", bit_rdata, e[ba[2:0]]);
   endtask : br

   task automatic stk(input logic psh, input logic pop, input logic [7:0] d);
      @(posedge clock);
      push_req <= psh;
      pop_req <= pop;
      push_data <= d;
      @(posedge clock);
      push_req <= 1'b0;
      pop_req <= 1'b0;
      mdl[8'h81] = psh ? mdl[8'h81] + 8'h01 : mdl[8'h81] - 8'h01;
      #1 check("swe", stack_we, psh);
      if (psh) check("sram", {stack_addr, stack_wdata}, {mdl[8'h81], d});
      chk_outs();
   endtask : stk

   // Instruction results and a 16-bit pointer load land in one cycle
   task automatic alu(input logic [31:0] r);
      @(posedge clock);
      alu_upd <= {1'b1, r[7:0], 1'b1, r[15:8], 1'b1, r[16], 1'b1, r[17], 1'b1, r[18]};
      mem_pointer_word_we <= 1'b1;
      mem_pointer_word_data <= r[31:16];
      @(posedge clock);
      alu_upd <= '0;
      mem_pointer_word_we <= 1'b0;
      {mdl[8'hF0], mdl[8'hE0]} = r[15:0];
      {mdl[8'h83], mdl[8'h82]} = r[31:16];
      {mdl[8'hD0][7], mdl[8'hD0][6], mdl[8'hD0][2]} = {r[16], r[17], r[18]};
      #1 chk_outs();
   endtask : alu

   ////////////////////////////////////////////////////////////////////////////
   // Nothing in the sequence waits on the design, so one limit covers a hang
   initial begin
      repeat (5000) @(posedge clock);
      n_fail++;
      end_sim();
   end

   initial begin
      reset_model();
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 11; i++) rd(tbl[i]);
      stk(1'b1, 1'b0, 8'hAA);
      stk(1'b1, 1'b1, 8'h55);
      stk(1'b0, 1'b1, 8'h00);
      for (int b = 0; b < 4; b++) wr(8'hD0, {3'h0, b[1:0], 3'h0});
      wr(8'h87, 8'hFF);
      for (int i = 0; i < 40; i++) begin
         rnd = lfsr(rnd);
         wr(tbl[rnd % 11], rnd[15:8]);
         rd(tbl[rnd % 11]);
      end
      for (int i = 0; i < 24; i++) begin
         rnd = lfsr(rnd);
         bw({(i < 8) ? 5'h1A : (i < 16) ? 5'h1C : 5'h1E, i[2:0]}, rnd[4]);
         br({(i < 8) ? 5'h1A : (i < 16) ? 5'h1C : 5'h1E, rnd[2:0]});
      end
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         alu(rnd);
         rd(8'hD0);
         stk(rnd[3], ~rnd[3], rnd[11:4]);
      end
      // Mid-run reset must bring every register back, whatever was written
      @(posedge clock);
      rst_n <= 1'b0;
      reset_model();
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      #1 chk_outs();
      wr(8'h82, 8'h3C);
      rd(8'h83);
      end_sim();
   end

endmodule : tb_csr_core_regs
`default_nettype wire
